//--- rtl/ocs_output_clock_path_select.sv
// Purpose: Main and auxiliary synthesis paths, multiplier taps and output clock selection.
// Assumes: All clocks are modelled as accumulator words and ticks on one system clock.
// Notes:   A tap whose frequency reaches half the system clock cannot be built; its synthesizer stops and holds its last level.
//
// The plain strobed port was left to the implementer.
`timescale 1ns/10ps
module ocs_output_clock_path_select
  import ocs_pkg::*;
(
  // Clock, reset, enable
  input  wire logic       i_sys_clk,
  input  wire logic       i_rst_b,
  input  wire logic       i_clk_en,
  // Register port
  input  wire logic [7:0] i_addr,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  output logic      [7:0] o_rdata,
  // Phase build-out step from the input alignment logic
  input  wire logic       i_pbo_valid,
  input  wire logic [7:0] i_pbo_step,
  // Clock outputs
  output logic [3:0]      o_main_out,
  output logic            o_out1_pecl_sel,
  output logic            o_frame_sync_8k_out,
  output logic            o_multiframe_sync_2k_out,
  output logic            o_t0_lock_clk,
  output logic            o_t4_lock_clk
);
  logic [7:0]  out1_signalling_select;
  logic [7:0]  frame_src;
  logic [7:0]  path_cfg;
  logic [7:0]  t0_lf_sel;
  logic [7:0]  t4_mux;
  logic [7:0]  t4_rate;
  logic [7:0]  lf_dig;
  logic [7:0]  phase_ofs;
  logic        phase_pend;
  logic [4:0]  out_sel [NUM_OUTPUTS];
  logic [4:0]  out_act [NUM_OUTPUTS];
  logic        lf_src_filt;
  logic [31:0] t0_fb_word;
  logic [31:0] t0_apll_in;
  logic [33:0] t0_apll_word;
  logic [2:0]  t4_rate_idx;
  logic [31:0] t4_fwd_word;
  logic [31:0] t4_apll_in;
  logic [33:0] t4_apll_word;
  logic [31:0] t4_fb_word;
  logic [31:0] lf_feed_word;
  logic        t0_fwd_tick;
  logic        t0_fwd_lvl;
  logic        t0_out_tick;
  logic        t0_out_lvl;
  logic        t4_fwd_tick;
  logic        t4_fwd_lvl;
  logic        lf_feed_tick;
  logic        lf_feed_lvl;
  logic [1:0]  dig_tick;
  logic [1:0]  dig_lvl;
  logic        t0_fb_lvl;
  logic        t4_fb_lvl;
  logic [T0_TAPS-1:0] t0_tap;
  logic [T4_TAPS-1:0] t4_tap;
  logic [12:0] t0_fcnt;
  logic [12:0] t4_fcnt;
  logic        t0_8k;
  logic        t4_8k;
  logic [1:0]  t0_mf;
  logic [1:0]  t4_mf;
  logic        t0_2k;
  logic        t4_2k;
  logic        t0_8k_wrap;
  logic        t4_8k_wrap;
  logic [7:0]  next_rdata;

  // Register writes.
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      out1_signalling_select <= RST_OUT1_SIG;
      frame_src              <= RST_ZERO;
      path_cfg               <= RST_ZERO;
      t0_lf_sel              <= RST_ZERO;
      t4_mux                 <= RST_ZERO;
      t4_rate                <= RST_ZERO;
      lf_dig                 <= RST_ZERO;
      phase_ofs              <= RST_ZERO;
    end else if (i_clk_en && i_wr) begin
      case (i_addr)
        ADDR_OUT1_SIG:  out1_signalling_select <= i_wdata;
        ADDR_FRAME_SRC: frame_src              <= i_wdata;
        ADDR_PATH_CFG:  path_cfg               <= i_wdata;
        ADDR_T0_LF_SEL: t0_lf_sel              <= i_wdata;
        ADDR_T4_MUX:    t4_mux                 <= i_wdata;
        ADDR_T4_RATE:   t4_rate                <= i_wdata;
        ADDR_LF_DIG:    lf_dig                 <= i_wdata;
        ADDR_PHASE_OFS: phase_ofs              <= i_wdata;
        default:        ;
      endcase
    end
  end

  // Output select registers; a write only stages the choice.
  genvar go;
  generate
    for (go = 0; go < NUM_OUTPUTS; go++) begin : g_osel
      always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
          out_sel[go] <= 5'h00;
        end else if (i_clk_en && i_wr && i_addr == ADDR_OUT_SEL0 + 8'(go)) begin
          out_sel[go] <= i_wdata[4:0];
        end
      end
    end
  endgenerate

  // A phase offset write is applied once to the forward synthesizer.
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      phase_pend <= 1'b0;
    end else if (i_clk_en) begin
      phase_pend <= i_wr && i_addr == ADDR_PHASE_OFS;
    end
  end

  // Main path words.
  always_comb begin
    lf_src_filt  = path_cfg[BIT_LF_FILT] && !path_cfg[BIT_T0_APLL_LF];
    lf_feed_word = (t0_lf_sel[2:0] < 3'h5) ? RATE_WORD[t0_lf_sel[2:0]] : WORD_77M76;
    t0_apll_in   = path_cfg[BIT_T0_APLL_LF] ? lf_feed_word : WORD_77M76;
    t0_apll_word = 34'(t0_apll_in) * 34'(APLL_MULT);
    // Filtered copy carries the multiplier input rate: 77.76 MHz, or the low-frequency feed rate while the multiplier is fed from that source.
    t0_fb_word   = path_cfg[BIT_T0_FB_ANA] ? t0_apll_word[33:2] : WORD_77M76;
  end

  // Auxiliary path words.
  always_comb begin
    t4_rate_idx  = t4_rate[2:0];
    t4_fwd_word  = path_cfg[BIT_T4_FROM_T0] ? WORD_77M76 : RATE_WORD[t4_rate_idx];
    t4_apll_in   = (t4_mux[2:0] == 3'h0 || t4_mux[2:0] > 3'h4) ? t4_fwd_word
                 : RATE_WORD[T4_MUX_IDX[t4_mux[2:0]]];
    t4_apll_word = 34'(t4_apll_in) * 34'(APLL_MULT);
    t4_fb_word   = path_cfg[BIT_T4_FB_ANA] ? t4_apll_word[33:2] : t4_fwd_word;
  end

  // Forward synthesizer: fixed 77.76 MHz plus build-out and programmed offset.
  ocs_nco #(.W(32)) u_t0_fwd (
    .i_sys_clk   (i_sys_clk),
    .i_rst_b     (i_rst_b),
    .i_clk_en    (i_clk_en),
    .i_word      (WORD_77M76),
    .i_phase_en  (phase_pend || (i_pbo_valid && path_cfg[BIT_PBO_EN])),
    .i_phase_add (phase_pend ? {phase_ofs, 24'h000000} : {i_pbo_step, 24'h000000}),
    .o_tick      (t0_fwd_tick),
    .o_level     (t0_fwd_lvl)
  );

  // Output synthesizer: same word as the forward one, so locked in frequency.
  ocs_nco #(.W(32)) u_t0_out (
    .i_sys_clk   (i_sys_clk),
    .i_rst_b     (i_rst_b),
    .i_clk_en    (i_clk_en),
    .i_word      (WORD_77M76),
    .i_phase_en  (1'b0),
    .i_phase_add (32'h00000000),
    .o_tick      (t0_out_tick),
    .o_level     (t0_out_lvl)
  );

  ocs_nco #(.W(32)) u_t0_fb (
    .i_sys_clk   (i_sys_clk),
    .i_rst_b     (i_rst_b),
    .i_clk_en    (i_clk_en),
    .i_word      (t0_fb_word >> FB_SHIFT),
    .i_phase_en  (1'b0),
    .i_phase_add (32'h00000000),
    .o_tick      (),
    .o_level     (t0_fb_lvl)
  );

  // Low-frequency synthesizer: multiplier feed plus two digital taps.
  ocs_nco #(.W(32)) u_lf_feed (
    .i_sys_clk   (i_sys_clk),
    .i_rst_b     (i_rst_b),
    .i_clk_en    (i_clk_en),
    .i_word      (lf_feed_word),
    .i_phase_en  (1'b0),
    .i_phase_add (32'h00000000),
    .o_tick      (lf_feed_tick),
    .o_level     (lf_feed_lvl)
  );

  genvar gd;
  generate
    for (gd = 0; gd < 2; gd++) begin : g_dig
      ocs_nco #(.W(32)) u_dig (
        .i_sys_clk   (i_sys_clk),
        .i_rst_b     (i_rst_b),
        .i_clk_en    (i_clk_en),
        .i_word      (RATE_WORD[lf_dig[4*gd +: 3]]),
        .i_phase_en  (1'b0),
        .i_phase_add (32'h00000000),
        .o_tick      (dig_tick[gd]),
        .o_level     (dig_lvl[gd])
      );
    end
  endgenerate

  // Auxiliary forward and feedback synthesizers; no phase input at all.
  ocs_nco #(.W(32)) u_t4_fwd (
    .i_sys_clk   (i_sys_clk),
    .i_rst_b     (i_rst_b),
    .i_clk_en    (i_clk_en),
    .i_word      (t4_fwd_word),
    .i_phase_en  (1'b0),
    .i_phase_add (32'h00000000),
    .o_tick      (t4_fwd_tick),
    .o_level     (t4_fwd_lvl)
  );

  ocs_nco #(.W(32)) u_t4_fb (
    .i_sys_clk   (i_sys_clk),
    .i_rst_b     (i_rst_b),
    .i_clk_en    (i_clk_en),
    .i_word      (t4_fb_word >> FB_SHIFT),
    .i_phase_en  (1'b0),
    .i_phase_add (32'h00000000),
    .o_tick      (),
    .o_level     (t4_fb_lvl)
  );

  // Post-divider taps: each is its own synthesizer at multiplier word over the divisor.
  genvar gt;
  generate
    for (gt = 0; gt < T0_TAPS; gt++) begin : g_t0_tap
      logic [33:0] tap_word;
      assign tap_word = t0_apll_word / 34'(T0_DIV[gt]);
      ocs_nco #(.W(32)) u_tap (
        .i_sys_clk   (i_sys_clk),
        .i_rst_b     (i_rst_b),
        .i_clk_en    (i_clk_en && tap_word < 34'h080000000),
        .i_word      (tap_word[31:0]),
        .i_phase_en  (1'b0),
        .i_phase_add (32'h00000000),
        .o_tick      (),
        .o_level     (t0_tap[gt])
      );
    end
    for (gt = 0; gt < T4_TAPS; gt++) begin : g_t4_tap
      logic [33:0] tap_word;
      assign tap_word = t4_apll_word / 34'(T4_DIV[gt]);
      ocs_nco #(.W(32)) u_tap (
        .i_sys_clk   (i_sys_clk),
        .i_rst_b     (i_rst_b),
        .i_clk_en    (i_clk_en && tap_word < 34'h080000000),
        .i_word      (tap_word[31:0]),
        .i_phase_en  (1'b0),
        .i_phase_add (32'h00000000),
        .o_tick      (),
        .o_level     (t4_tap[gt])
      );
    end
  endgenerate

  // Frame dividers: 8 kHz toggles every half period of ticks, 2 kHz every fourth toggle.
  assign t0_8k_wrap = t0_out_tick && t0_fcnt == RATE_HALF8K[0] - 13'h0001;
  assign t4_8k_wrap = t4_fwd_tick && t4_fcnt == RATE_HALF8K[path_cfg[BIT_T4_FROM_T0] ? 3'h0 : t4_rate_idx] - 13'h0001;

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      t0_fcnt <= 13'h0000;
      t0_8k   <= 1'b0;
      t0_mf   <= 2'h0;
      t0_2k   <= 1'b0;
    end else if (i_clk_en && t0_out_tick) begin
      t0_fcnt <= t0_8k_wrap ? 13'h0000 : t0_fcnt + 13'h0001;
      if (t0_8k_wrap) begin
        t0_8k <= !t0_8k;
        t0_mf <= t0_mf + 2'h1;
        if (t0_mf == 2'(FRAME_DIV2K - 1)) begin
          t0_2k <= !t0_2k;
        end
      end
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      t4_fcnt <= 13'h0000;
      t4_8k   <= 1'b0;
      t4_mf   <= 2'h0;
      t4_2k   <= 1'b0;
    end else if (i_clk_en && t4_fwd_tick) begin
      t4_fcnt <= t4_8k_wrap ? 13'h0000 : t4_fcnt + 13'h0001;
      if (t4_8k_wrap) begin
        t4_8k <= !t4_8k;
        t4_mf <= t4_mf + 2'h1;
        if (t4_mf == 2'(FRAME_DIV2K - 1)) begin
          t4_2k <= !t4_2k;
        end
      end
    end
  end

  // Dedicated sync outputs never look at the auxiliary path.
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_frame_sync_8k_out      <= 1'b0;
      o_multiframe_sync_2k_out <= 1'b0;
      o_out1_pecl_sel          <= 1'b0;
      o_t0_lock_clk            <= 1'b0;
      o_t4_lock_clk            <= 1'b0;
    end else if (i_clk_en) begin
      o_frame_sync_8k_out      <= t0_8k;
      o_multiframe_sync_2k_out <= t0_2k;
      o_out1_pecl_sel          <= out1_signalling_select[0];
      o_t0_lock_clk            <= t0_fb_lvl;
      o_t4_lock_clk            <= t4_fb_lvl;
    end
  end

  // Main output muxes. Staged choices are taken only while the output sits low,
  // which trades a delay of up to half a period for freedom from runt pulses.
  function automatic logic pick(input logic [4:0] sel, input logic [T0_TAPS-1:0] t0, input logic [T4_TAPS-1:0] t4,
                                input logic [1:0] dg, input logic aux_frame, input logic k2_0, input logic k8_0,
                                input logic k2_4, input logic k8_4);
    logic r;
    r = 1'b0;
    case (sel[3:0])
      OSEL_DIG1: r = dg[0];
      OSEL_DIG2: r = dg[1];
      OSEL_2K:   r = aux_frame ? k2_4 : k2_0;
      OSEL_8K:   r = aux_frame ? k8_4 : k8_0;
      default: begin
        if (sel[BIT_OSEL_AUX]) begin
          r = (sel[2:0] < 3'(T4_TAPS)) ? t4[sel[2:0]] : 1'b0;
        end else begin
          r = t0[sel[2:0]];
        end
      end
    endcase
    return r;
  endfunction

  generate
    for (go = 0; go < NUM_OUTPUTS; go++) begin : g_out
      always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
          out_act[go]    <= 5'h00;
          o_main_out[go] <= 1'b0;
        end else if (i_clk_en) begin
          if (!o_main_out[go]) begin
            out_act[go] <= out_sel[go];
          end
          o_main_out[go] <= pick(out_act[go], t0_tap, t4_tap, dig_lvl, frame_src[BIT_FRAME_AUX],
                                 t0_2k, t0_8k, t4_2k, t4_8k);
        end
      end
    end
  endgenerate

  // Read port; unmapped addresses read zero.
  always_comb begin
    next_rdata = 8'h00;
    case (i_addr)
      ADDR_OUT1_SIG:  next_rdata = out1_signalling_select;
      ADDR_FRAME_SRC: next_rdata = frame_src;
      ADDR_PATH_CFG:  next_rdata = path_cfg;
      ADDR_T0_LF_SEL: next_rdata = t0_lf_sel;
      ADDR_T4_MUX:    next_rdata = t4_mux;
      ADDR_T4_RATE:   next_rdata = t4_rate;
      ADDR_LF_DIG:    next_rdata = lf_dig;
      ADDR_PHASE_OFS: next_rdata = phase_ofs;
      ADDR_STATUS:    next_rdata = {lf_src_filt, t4_2k, t4_8k, 1'b0, o_main_out};
      default: begin
        if (i_addr >= ADDR_OUT_SEL0 && i_addr < ADDR_OUT_SEL0 + 8'(NUM_OUTPUTS)) begin
          next_rdata = {3'h0, out_sel[i_addr[1:0]]};
        end
      end
    endcase
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_rdata <= 8'h00;
    end else if (i_clk_en) begin
      o_rdata <= i_rd ? next_rdata : 8'h00;
    end
  end

  // Checks.
  sequence s_sig_write;
    i_clk_en && i_wr && i_addr == ADDR_OUT1_SIG;
  endsequence
  sequence s_two_enabled;
    i_clk_en [*2];
  endsequence

  AST_OUT1_SIG: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
    s_sig_write ##1 s_two_enabled |-> o_out1_pecl_sel == $past(i_wdata[0], 2))
    else $error("output one standard does not follow register");
  AST_LF_FORCED: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
    path_cfg[BIT_T0_APLL_LF] |-> !lf_src_filt)
    else $error("low-frequency source not forced raw");
  AST_T0_X4: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
    t0_apll_word == {t0_apll_in, 2'b00} && (!path_cfg[BIT_T0_APLL_LF] -> t0_apll_in == WORD_77M76))
    else $error("main multiplier not four times its input");
  AST_T4_MUX: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
    t4_mux[2:0] == 3'h1 |-> t4_apll_word == {RATE_WORD[1], 2'b00})
    else $error("auxiliary mux source wrong");
  AST_FRAME_T0: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
    i_clk_en && t0_8k_wrap ##1 i_clk_en |=> o_frame_sync_8k_out != $past(o_frame_sync_8k_out))
    else $error("frame sync did not follow main divider");
  AST_FRAME_ONLY_T0: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
    $changed(t0_8k) |-> $past(t0_8k_wrap && i_clk_en))
    else $error("frame divider moved without main wrap");
  AST_NO_RUNT: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
    $changed(out_act[0]) |-> !$past(o_main_out[0]))
    else $error("output select changed while output high");
  AST_FREEZE: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
    !i_clk_en |=> $stable(o_main_out) && $stable(o_rdata))
    else $error("state moved with clock enable low");
  AST_READ: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
    i_clk_en && i_rd && i_addr == ADDR_FRAME_SRC |=> o_rdata == $past(frame_src))
    else $error("read data wrong");
  AST_T0_FIXED: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
    i_clk_en && !phase_pend && !(i_pbo_valid && path_cfg[BIT_PBO_EN]) |=>
    u_t0_fwd.acc == $past(u_t0_fwd.acc) + WORD_77M76)
    else $error("forward synthesizer step wrong");
endmodule

//--- rtl/ocs_pkg.sv
// Purpose: Shared constants for the output clock path select block.
// Assumes: Frequency words are phase increments of a 32-bit accumulator clocked at the system clock.
// Notes:   Words below stand for the documented 204.8 MHz system clock.
package ocs_pkg;
  // Register offsets.
  localparam logic [7:0] ADDR_OUT1_SIG  = 8'h3A;
  localparam logic [7:0] ADDR_FRAME_SRC = 8'h7A;
  localparam logic [7:0] ADDR_PATH_CFG  = 8'h60;
  localparam logic [7:0] ADDR_T0_LF_SEL = 8'h61;
  localparam logic [7:0] ADDR_T4_MUX    = 8'h62;
  localparam logic [7:0] ADDR_T4_RATE   = 8'h63;
  localparam logic [7:0] ADDR_OUT_SEL0  = 8'h64;
  localparam logic [7:0] ADDR_PHASE_OFS = 8'h68;
  localparam logic [7:0] ADDR_STATUS    = 8'h69;
  localparam logic [7:0] ADDR_LF_DIG    = 8'h6A;
  // Field positions.
  localparam int BIT_FRAME_AUX   = 7;
  localparam int BIT_T0_FB_ANA   = 0;
  localparam int BIT_LF_FILT     = 1;
  localparam int BIT_T0_APLL_LF  = 2;
  localparam int BIT_T4_FROM_T0  = 3;
  localparam int BIT_T4_FB_ANA   = 4;
  localparam int BIT_PBO_EN      = 5;
  localparam int BIT_OSEL_AUX    = 4;
  // Reset values.
  localparam logic [7:0] RST_OUT1_SIG = 8'h00;
  localparam logic [7:0] RST_ZERO     = 8'h00;
  // Rate indices and frequency words (f / 204.8 MHz * 2^32).
  localparam int NUM_RATES = 8;
  localparam logic [31:0] WORD_77M76 = 32'h61333333;
  localparam logic [31:0] RATE_WORD [NUM_RATES] = '{32'h61333333, 32'h1EB851EB, 32'h28F5C28F, 32'h2E51EB85,
                                                     32'h1EE147AD, 32'h2AF5C28F, 32'h37EB8619, 32'h61333333};
  // Half period of an 8 kHz frame clock, counted in ticks of each rate.
  localparam logic [12:0] RATE_HALF8K [NUM_RATES] = '{13'h12FC, 13'h0600, 13'h0800, 13'h090C,
                                                       13'h0608, 13'h0864, 13'h0AEC, 13'h12FC};
  // T4 auxiliary mux indices into the rate table.
  localparam logic [2:0] T4_MUX_IDX [5] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4};
  // Post-divider taps behind each multiplier.
  localparam int T0_TAPS = 8;
  localparam int T4_TAPS = 7;
  localparam int T0_DIV [T0_TAPS] = '{1, 2, 4, 6, 8, 12, 16, 48};
  localparam int T4_DIV [T4_TAPS] = '{2, 4, 8, 12, 16, 48, 64};
  localparam int APLL_MULT = 4;
  // Output select codes beyond the divider taps.
  localparam logic [3:0] OSEL_DIG1 = 4'h8;
  localparam logic [3:0] OSEL_DIG2 = 4'h9;
  localparam logic [3:0] OSEL_2K   = 4'hA;
  localparam logic [3:0] OSEL_8K   = 4'hB;
  localparam int FB_SHIFT     = 4;
  localparam int NUM_OUTPUTS  = 4;
  localparam int FRAME_DIV2K  = 4;
endpackage

//--- rtl/ocs_nco.sv
// Purpose: Digital frequency synthesizer built as a phase accumulator on the system clock.
// Assumes: Word below 2^31 so that every output edge is a separate system clock edge.
// Notes:   Output edges can only fall on system clock edges, so jitter is one clock period.
`timescale 1ns/10ps
module ocs_nco
  import ocs_pkg::*;
#(
  parameter int W = 32
) (
  // Clock and reset
  input  wire logic         i_sys_clk,
  input  wire logic         i_rst_b,
  input  wire logic         i_clk_en,
  // Control
  input  wire logic [W-1:0] i_word,
  input  wire logic         i_phase_en,
  input  wire logic [W-1:0] i_phase_add,
  // Synthesized clock
  output logic              o_tick,
  output logic              o_level
);
  logic [W-1:0] acc;
  logic [W:0]   next_acc;

  always_comb begin
    next_acc = {1'b0, acc} + {1'b0, i_word} + (i_phase_en ? {1'b0, i_phase_add} : {(W+1){1'b0}});
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      acc     <= '0;
      o_tick  <= 1'b0;
      o_level <= 1'b0;
    end else if (i_clk_en) begin
      acc     <= next_acc[W-1:0];
      o_tick  <= next_acc[W];
      o_level <= next_acc[W-1];
    end
  end
endmodule

//--- tb/ocs_clk_sink.sv
// Purpose: Downstream equipment that counts rising edges on each received clock.
// Assumes: Clocks are levels sampled on the system clock.
// Notes:   Counting, not timing, so a one-edge slack is left to the bench.
`timescale 1ns/10ps
module ocs_clk_sink (
  // Clock
  input  wire logic       i_sys_clk,
  // Control
  input  wire logic       i_clear,
  // Received clocks
  input  wire logic [7:0] i_clk,
  // Edge counts
  output int              o_cnt [8]
);
  logic [7:0] prev;

  always @(posedge i_sys_clk) begin
    prev <= i_clk;
    for (int n = 0; n < 8; n++) begin
      if (i_clear) begin
        o_cnt[n] <= 0;
      end else if (i_clk[n] === 1'b1 && prev[n] === 1'b0) begin
        o_cnt[n] <= o_cnt[n] + 1;
      end
    end
  end
endmodule

//--- tb/ocs_output_clock_path_select_tb_top.sv
// Purpose: Register and output frequency tests of the output clock path select block.
// Assumes: One bench cycle stands for one 204.8 MHz system clock cycle.
// Notes:   1024 cycles hold five times the frequency in MHz of edges.
`timescale 1ns/10ps
module ocs_output_clock_path_select_tb_top;
  import ocs_pkg::*;
  logic       i_sys_clk = 1'b0;
  logic       i_rst_b   = 1'b0;
  logic [7:0] i_addr    = 8'h00;
  logic [7:0] i_wdata   = 8'h00;
  logic       i_wr      = 1'b0;
  logic       i_rd      = 1'b0;
  logic       i_pbo_valid = 1'b0;
  logic [7:0] i_pbo_step  = 8'h00;
  logic       clear     = 1'b1;
  logic       clk_en    = 1'b1;
  logic       o_t0_lock_clk;
  logic       o_t4_lock_clk;
  logic [7:0] o_rdata;
  logic [3:0] o_main_out;
  logic       o_out1_pecl_sel;
  logic       o_frame_sync_8k_out;
  logic       o_multiframe_sync_2k_out;
  int         cnt [8];
  int         error_cnt = 0;
  int         n_tests   = 0;
  logic [7:0] d;

  always #20 i_sys_clk = ~i_sys_clk;

  ocs_output_clock_path_select uut (
    .i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b), .i_clk_en(clk_en), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_pbo_valid(i_pbo_valid), .i_pbo_step(i_pbo_step),
    .o_main_out(o_main_out), .o_out1_pecl_sel(o_out1_pecl_sel), .o_frame_sync_8k_out(o_frame_sync_8k_out),
    .o_multiframe_sync_2k_out(o_multiframe_sync_2k_out),
    .o_t0_lock_clk(o_t0_lock_clk), .o_t4_lock_clk(o_t4_lock_clk));

  ocs_clk_sink sink (
    .i_sys_clk(i_sys_clk), .i_clear(clear),
    .i_clk({o_t4_lock_clk, o_t0_lock_clk, o_multiframe_sync_2k_out, o_frame_sync_8k_out, o_main_out}),
    .o_cnt(cnt));

  task automatic stop_test;
    if (error_cnt == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge i_sys_clk);
    i_addr  <= a;
    i_wdata <= v;
    i_wr    <= 1'b1;
    @(posedge i_sys_clk);
    i_wr    <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge i_sys_clk);
    i_addr <= a;
    i_rd   <= 1'b1;
    @(posedge i_sys_clk);
    i_rd   <= 1'b0;
    #1 v = o_rdata;
  endtask

  // A tap at or above half the system clock cannot be synthesized and must stay low.
  task automatic meas(input int k, input real f);
    int e;
    e = (f >= 102.4) ? 0 : int'($floor(f * 5.0));
    repeat (100) @(posedge i_sys_clk);
    clear <= 1'b0;
    repeat (1024) @(posedge i_sys_clk);
    clear <= 1'b1;
    #1 chk(8'(cnt[k] >= e - 1 && cnt[k] <= e + 1), 8'h01);
  endtask

  initial begin
    repeat (95000) @(posedge i_sys_clk);
    error_cnt++;
    stop_test();
  end

  initial begin
    repeat (10) @(posedge i_sys_clk);
    i_rst_b <= 1'b1;
    rd(ADDR_OUT1_SIG, d);
    chk(d, RST_OUT1_SIG);
    chk(8'(o_out1_pecl_sel), 8'h00);
    wr(ADDR_OUT1_SIG, 8'h01);
    rd(ADDR_OUT1_SIG, d);
    chk(d, 8'h01);
    chk(8'(o_out1_pecl_sel), 8'h01);
    rd(8'h10, d);
    chk(d, 8'h00);
    @(posedge i_sys_clk);
    #1 chk(o_rdata, 8'h00);
    wr(ADDR_FRAME_SRC, 8'h80);
    rd(ADDR_FRAME_SRC, d);
    chk(d, 8'h80);
    // Build-out and offset steps move phase only, so the main taps keep their rate.
    wr(ADDR_PATH_CFG, 8'h20);
    for (int i = 0; i < T0_TAPS; i++) begin
      wr(ADDR_OUT_SEL0 + 8'(i % 4), 8'(i));
      wr(ADDR_PHASE_OFS, 8'h40);
      @(posedge i_sys_clk);
      i_pbo_valid <= 1'b1;
      i_pbo_step  <= 8'h20;
      @(posedge i_sys_clk);
      i_pbo_valid <= 1'b0;
      meas(i % 4, 77.76 * APLL_MULT / T0_DIV[i]);
    end
    // Each output in turn is pointed at an aux tap; earlier outputs stay on the aux taps they were given.
    for (int i = 0; i < T4_TAPS; i++) begin
      wr(ADDR_OUT_SEL0 + 8'(i % 4), 8'h10 | 8'(i));
      meas(i % 4, 77.76 * APLL_MULT / T4_DIV[i]);
    end
    // Aux multiplier fed from the main 12E1 clock, seen on the aux /4 tap.
    wr(ADDR_T4_MUX, 8'h01);
    wr(ADDR_OUT_SEL0, 8'h11);
    meas(0, 24.576);
    wr(ADDR_T4_MUX, 8'h00);
    // Filtered feedback on both paths leaves the rate of the lock clocks unchanged.
    wr(ADDR_PATH_CFG, 8'h31);
    meas(6, 77.76 / 16.0);
    meas(7, 77.76 / 16.0);
    // Main multiplier fed from the low-frequency 12E1 rate, so the /1 tap becomes buildable.
    wr(ADDR_T0_LF_SEL, 8'h01);
    wr(ADDR_PATH_CFG, 8'h06);
    wr(ADDR_OUT_SEL0, 8'h00);
    meas(0, 24.576 * APLL_MULT);
    rd(ADDR_STATUS, d);
    chk(8'(d[7]), 8'h00);
    wr(ADDR_PATH_CFG, 8'h02);
    rd(ADDR_STATUS, d);
    chk(8'(d[7]), 8'h01);
    wr(ADDR_LF_DIG, 8'h21);
    wr(ADDR_OUT_SEL0 + 8'h01, 8'h08);
    wr(ADDR_OUT_SEL0 + 8'h02, 8'h09);
    meas(1, 24.576);
    meas(2, 32.768);
    // Clock enable low freezes the outputs and refuses register writes.
    @(posedge i_sys_clk);
    clk_en <= 1'b0;
    #1 d = {4'h0, o_main_out};
    wr(ADDR_OUT1_SIG, 8'h00);
    repeat (20) @(posedge i_sys_clk);
    #1 chk({4'h0, o_main_out}, d);
    @(posedge i_sys_clk);
    clk_en <= 1'b1;
    rd(ADDR_OUT1_SIG, d);
    chk(d, 8'h01);
    // The frame sync stays on the main path although the aux source is chosen for outputs.
    wr(ADDR_OUT_SEL0 + 8'h02, 8'h0B);
    wr(ADDR_OUT_SEL0 + 8'h03, 8'h0A);
    repeat (100) @(posedge i_sys_clk);
    clear <= 1'b0;
    repeat (51200) @(posedge i_sys_clk);
    #1 chk(8'(cnt[4] >= 1 && cnt[4] <= 3), 8'h01);
    chk(8'(cnt[5]), 8'h01);
    chk(8'(cnt[2] >= 1 && cnt[2] <= 3), 8'h01);
    chk(8'(cnt[3]), 8'h01);
    stop_test();
  end
endmodule
